// ---- pkg/sib_pkg.sv ----
package sib_pkg;

    // ---------------------------------------------------------------
    // bus addresses and special indices
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_WR      = 8'hD2;
    localparam logic [7:0] ADDR_RD      = 8'hD3;
    localparam logic [7:0] IDX_STRAP    = 8'h06;
    localparam logic [7:0] IDX_VREV     = 8'h07;
    localparam logic [7:0] IDX_COUNT    = 8'h08;
    localparam logic [7:0] IDX_DEVID    = 8'h09;
    localparam logic [7:0] NUM_REGS     = 8'h0A;
    localparam int         STRAP_BIT    = 4;
    localparam logic [7:0] TX_IDLE_BYTE = 8'hFF;
    localparam logic [3:0] BYTE_BITS    = 4'h8;

    // ---------------------------------------------------------------
    // reset values and writable-bit masks
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_B0 = 8'hFF;
    localparam logic [7:0] RST_B1 = 8'h9E;
    localparam logic [7:0] RST_B2 = 8'h3F;
    localparam logic [7:0] RST_B5 = 8'h0F;
    localparam logic [7:0] RST_B6 = 8'h08;
    localparam logic [7:0] RST_B8 = 8'h0A;
    localparam logic [7:0] MSK_B0 = 8'hFF;
    localparam logic [7:0] MSK_B1 = 8'h9F;
    localparam logic [7:0] MSK_B2 = 8'h3F;
    localparam logic [7:0] MSK_B5 = 8'h1F;
    localparam logic [7:0] MSK_B6 = 8'hCF;
    localparam logic [7:0] MSK_B8 = 8'hFF;

    // ---------------------------------------------------------------
    // link state machine and byte roles
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b010,
        ST_TX   = 3'b011,
        ST_TACK = 3'b100,
        ST_LOAD = 3'b101
    } sib_state_t;

    typedef enum logic [1:0] {
        RL_ADDR  = 2'b00,
        RL_INDEX = 2'b01,
        RL_COUNT = 2'b10,
        RL_DATA  = 2'b11
    } sib_role_t;

    // bits software may change; all else keeps its value
    function automatic logic [7:0] sib_wmask(input logic [7:0] idx);
        case (idx)
            8'h00:   sib_wmask = MSK_B0;
            8'h01:   sib_wmask = MSK_B1;
            8'h02:   sib_wmask = MSK_B2;
            8'h05:   sib_wmask = MSK_B5;
            8'h06:   sib_wmask = MSK_B6;
            8'h08:   sib_wmask = MSK_B8;
            default: sib_wmask = 8'h00;
        endcase
    endfunction : sib_wmask

    function automatic logic [7:0] sib_rst_val(input logic [7:0] idx);
        case (idx)
            8'h00:   sib_rst_val = RST_B0;
            8'h01:   sib_rst_val = RST_B1;
            8'h02:   sib_rst_val = RST_B2;
            8'h05:   sib_rst_val = RST_B5;
            8'h06:   sib_rst_val = RST_B6;
            8'h08:   sib_rst_val = RST_B8;
            default: sib_rst_val = 8'h00;
        endcase
    endfunction : sib_rst_val

endpackage : sib_pkg

// ---- hdl/sib_regmem.sv ----
// small register store; read data always registered
module sib_regmem
    import sib_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       we,
    input  wire logic [3:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [3:0] raddr,
    output logic      [7:0] rdata_q
);

    logic [7:0] mem_q [16];

    // --------------------------------------------------------------
    // storage
    // --------------------------------------------------------------
    // reset loads the documented defaults into every entry
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                mem_q[i] <= sib_rst_val(8'(i));
            end
            rdata_q <= 8'h00;
        end else begin
            if (we) begin
                mem_q[waddr] <= wdata;
            end
            rdata_q <= mem_q[raddr];
        end
    end

endmodule : sib_regmem

// ---- hdl/sib_smbus_slave.sv ----
// What this block does
// - The starting index byte follows the address in both sequences and the device acknowledges it.
// - In a block write the byte count follows the index and the device acknowledges it.
// - The data bytes for indices N upward follow, each acknowledged on its own.
// - After the repeated start the read address comes and is acknowledged before any data.
// - A block read returns the byte count first and the register bytes after it.
// - The number of register bytes returned follows the count last written to index 8.
// - Only addresses D2 (write) and D3 (read) are answered; others are ignored.
module sib_smbus_slave
    import sib_pkg::*;
#(
    parameter logic [7:0] VEND_REV_ID = 8'h5A, // value arbitrary
    parameter logic [7:0] DEVICE_ID   = 8'hA5  // value arbitrary
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       link_clk,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       freq_strap,
    input  wire logic       cfg_ready,
    output logic            scl_out,
    output logic            scl_oe,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            cfg_valid,
    output logic      [7:0] cfg_index,
    output logic      [7:0] cfg_data
);

    // --------------------------------------------------------------
    // link domain: reset and pin synchronisers
    // --------------------------------------------------------------
    logic       lrst_s1_q, lrst_q;
    logic       scl_s1_q, scl_s2_q, scl_s3_q;
    logic       sda_s1_q, sda_s2_q, sda_s3_q;
    logic       ack_s1_q, ack_s2_q;
    sib_state_t state_q;
    sib_role_t  role_q;
    logic [7:0] rx_sh_q, tx_sh_q, idx_q, left_q;
    logic [3:0] bit_cnt_q;
    logic       rd_dir_q, first_q, fetch_q, sda_oe_q, scl_oe_q, drv_q;
    logic       req_tgl_q, req_wr_q;
    logic [7:0] req_idx_q, req_dat_q;
    logic [7:0] rdata_q;
    logic       ack_tgl_q;

    // reset reaches the link side through two flops as well
    always_ff @(posedge link_clk) begin
        lrst_s1_q <= rst_n;
        lrst_q    <= lrst_s1_q;
    end

    // only stage 2 and its history stage 3 feed any logic
    always_ff @(posedge link_clk) begin
        if (!lrst_q) begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
            {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
            {ack_s1_q, ack_s2_q}           <= 2'h0;
        end else begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_in, scl_s1_q, scl_s2_q};
            {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_in, sda_s1_q, sda_s2_q};
            {ack_s1_q, ack_s2_q}           <= {ack_tgl_q, ack_s1_q};
        end
    end

    // --------------------------------------------------------------
    // link domain: bus events and decodes
    // --------------------------------------------------------------
    wire scl_rise  = scl_s2_q & ~scl_s3_q;
    wire scl_fall  = ~scl_s2_q & scl_s3_q;
    wire bus_start = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
    wire bus_stop  = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;
    wire busy      = req_tgl_q ^ ack_s2_q;
    wire decide    = scl_fall & (state_q == ST_RX) & (bit_cnt_q == BYTE_BITS);
    wire is_wr_adr = rx_sh_q == ADDR_WR;
    wire is_rd_adr = rx_sh_q == ADDR_RD;
    wire issue_wr  = decide & (role_q == RL_DATA);
    wire issue_cnt = decide & (role_q == RL_ADDR) & is_rd_adr;
    wire host_ack  = scl_rise & (state_q == ST_TACK) & ~sda_s2_q;
    wire issue_dat = host_ack & (left_q != 8'h00);
    wire issue     = issue_wr | issue_cnt | issue_dat;
    // rdata_q is only read while no request is open, so it is stable
    wire [7:0] load_byte = fetch_q ? rdata_q : TX_IDLE_BYTE;

    // --------------------------------------------------------------
    // link domain: byte-level state machine
    // --------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (!lrst_q) begin
            state_q   <= ST_IDLE;
            role_q    <= RL_ADDR;
            rx_sh_q   <= 8'h00;
            tx_sh_q   <= 8'h00;
            idx_q     <= 8'h00;
            left_q    <= 8'h00;
            bit_cnt_q <= 4'h0;
            rd_dir_q  <= 1'b0;
            first_q   <= 1'b0;
            fetch_q   <= 1'b0;
            sda_oe_q  <= 1'b0;
        end else if (bus_stop) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else if (bus_start) begin  // start and repeated start alike
            state_q   <= ST_RX;
            role_q    <= RL_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_q  <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        rx_sh_q   <= {rx_sh_q[6:0], sda_s2_q};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (decide) begin
                        if (role_q == RL_ADDR && !is_wr_adr && !is_rd_adr) begin
                            state_q <= ST_IDLE;
                        end else begin
                            state_q  <= ST_ACK;
                            sda_oe_q <= 1'b1;
                        end
                        unique case (role_q)
                            RL_ADDR: begin
                                rd_dir_q <= is_rd_adr;
                                role_q   <= RL_INDEX;
                                first_q  <= is_rd_adr;
                                fetch_q  <= is_rd_adr;
                            end
                            RL_INDEX: begin
                                idx_q  <= rx_sh_q;
                                role_q <= RL_COUNT;
                            end
                            RL_COUNT: role_q <= RL_DATA;
                            RL_DATA:  idx_q  <= idx_q + 8'h01;
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q  <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        state_q   <= rd_dir_q ? ST_LOAD : ST_RX;
                    end
                end
                ST_LOAD: begin
                    // wait here with clock held low until data arrives
                    if (!busy) begin
                        tx_sh_q   <= load_byte;
                        sda_oe_q  <= ~load_byte[7];
                        bit_cnt_q <= 4'h1;
                        state_q   <= ST_TX;
                        first_q   <= 1'b0;
                        if (first_q) begin
                            left_q <= rdata_q;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall && bit_cnt_q == BYTE_BITS) begin
                        sda_oe_q <= 1'b0;
                        state_q  <= ST_TACK;
                    end else if (scl_fall) begin
                        tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
                        sda_oe_q  <= ~tx_sh_q[6];
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                end
                ST_TACK: begin
                    if (scl_rise && sda_s2_q) begin
                        state_q <= ST_IDLE;
                    end else if (host_ack) begin
                        fetch_q <= issue_dat;
                        if (issue_dat) begin
                            idx_q  <= idx_q + 8'h01;
                            left_q <= left_q - 8'h01;
                        end
                    end else if (scl_fall) begin
                        state_q <= ST_LOAD;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // link domain: request toggle and clock stretching
    // --------------------------------------------------------------
    // request words are held from the toggle until the answer returns
    always_ff @(posedge link_clk) begin
        if (!lrst_q) begin
            req_tgl_q <= 1'b0;
            req_wr_q  <= 1'b0;
            req_idx_q <= 8'h00;
            req_dat_q <= 8'h00;
            scl_oe_q  <= 1'b0;
            drv_q     <= 1'b0;
        end else begin
            if (issue) begin
                req_tgl_q <= ~req_tgl_q;
                req_wr_q  <= issue_wr;
                req_idx_q <= issue_cnt ? IDX_COUNT : idx_q;
                req_dat_q <= rx_sh_q;
            end
            // stretch only while scl is already low, never a fake edge; held one cycle past the load
            // so the first data bit settles on sda before scl is let go
            scl_oe_q <= (busy & ((state_q == ST_ACK) | (state_q == ST_LOAD))) | (scl_oe_q & (state_q == ST_LOAD));
            drv_q    <= 1'b0;
        end
    end

    assign scl_oe  = scl_oe_q;
    assign sda_oe  = sda_oe_q;
    assign scl_out = drv_q;
    assign sda_out = drv_q;

    // --------------------------------------------------------------
    // system domain: request sync, register store, answer
    // --------------------------------------------------------------
    logic       rq_s1_q, rq_s2_q, rq_s3_q, st_s1_q, st_s2_q;
    logic       pend_q, rd_stage_q, v0_q, v1_q;
    logic [7:0] mem_rd, i0_q, d0_q, i1_q, d1_q;

    wire       new_req  = rq_s2_q ^ rq_s3_q;
    wire       in_ready = ~v1_q;
    wire       push     = pend_q & req_wr_q & in_ready;
    wire       pop      = v0_q & cfg_ready;
    wire [7:0] wr_val   = req_dat_q & sib_wmask(req_idx_q);
    // indices past the table would alias into the store, so they never write
    wire       mem_we   = push & (req_idx_q < NUM_REGS);

    // read-only fields are merged in here rather than stored
    function automatic logic [7:0] rd_val(input logic [7:0] idx, input logic [7:0] m, input logic s);
        if (idx >= NUM_REGS)        rd_val = 8'h00;
        else if (idx == IDX_VREV)   rd_val = VEND_REV_ID;
        else if (idx == IDX_DEVID)  rd_val = DEVICE_ID;
        else if (idx == IDX_STRAP)  rd_val = m | (8'(s) << STRAP_BIT);
        else                        rd_val = m;
    endfunction : rd_val

    sib_regmem u_mem (
        .clk     (sys_clk),
        .rst_n   (rst_n),
        .we      (mem_we),
        .waddr   (req_idx_q[3:0]),
        .wdata   (wr_val),
        .raddr   (req_idx_q[3:0]),
        .rdata_q (mem_rd)
    );

    // a full buffer withholds the answer, so scl stays stretched
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {rq_s1_q, rq_s2_q, rq_s3_q} <= 3'h0;
            {st_s1_q, st_s2_q}          <= 2'h0;
            pend_q     <= 1'b0;
            rd_stage_q <= 1'b0;
            ack_tgl_q  <= 1'b0;
            rdata_q    <= 8'h00;
        end else begin
            {rq_s1_q, rq_s2_q, rq_s3_q} <= {req_tgl_q, rq_s1_q, rq_s2_q};
            {st_s1_q, st_s2_q}          <= {freq_strap, st_s1_q};
            if (new_req) begin
                pend_q <= 1'b1;
            end else if (push) begin
                pend_q    <= 1'b0;
                ack_tgl_q <= ~ack_tgl_q;
            end else if (pend_q && !req_wr_q) begin
                rd_stage_q <= ~rd_stage_q;
                if (rd_stage_q) begin
                    rdata_q   <= rd_val(req_idx_q, mem_rd, st_s2_q);
                    pend_q    <= 1'b0;
                    ack_tgl_q <= ~ack_tgl_q;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // system domain: two-entry buffer toward the consumer
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {v0_q, v1_q} <= 2'h0;
            {i0_q, d0_q, i1_q, d1_q} <= 32'h0;
        end else if (pop) begin
            v0_q <= v1_q | push;
            v1_q <= v1_q & push;
            i0_q <= v1_q ? i1_q : req_idx_q;
            d0_q <= v1_q ? d1_q : wr_val;
            if (v1_q) begin
                i1_q <= req_idx_q;
                d1_q <= wr_val;
            end
        end else if (push && !v0_q) begin
            v0_q <= 1'b1;
            i0_q <= req_idx_q;
            d0_q <= wr_val;
        end else if (push) begin
            v1_q <= 1'b1;
            i1_q <= req_idx_q;
            d1_q <= wr_val;
        end
    end

    assign cfg_valid = v0_q;
    assign cfg_index = i0_q;
    assign cfg_data  = d0_q;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_addr_ignore;
        @(posedge link_clk) disable iff (!lrst_q)
        decide && role_q == RL_ADDR && !is_wr_adr && !is_rd_adr |=> state_q == ST_IDLE && !sda_oe_q;
    endproperty
    a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address answered");

    property p_wr_addr_ack;
        @(posedge link_clk) disable iff (!lrst_q)
        decide && role_q == RL_ADDR && is_wr_adr |=> sda_oe_q && state_q == ST_ACK && !rd_dir_q;
    endproperty
    a_wr_addr_ack: assert property (p_wr_addr_ack) else $error("write address not acked");

    property p_index_take;
        @(posedge link_clk) disable iff (!lrst_q)
        decide && role_q == RL_INDEX |=> sda_oe_q && idx_q == $past(rx_sh_q) && role_q == RL_COUNT;
    endproperty
    a_index_take: assert property (p_index_take) else $error("index not taken");

    property p_count_ack;
        @(posedge link_clk) disable iff (!lrst_q)
        decide && role_q == RL_COUNT |=> sda_oe_q && role_q == RL_DATA;
    endproperty
    a_count_ack: assert property (p_count_ack) else $error("count byte not acked");

    property p_data_wr;
        @(posedge link_clk) disable iff (!lrst_q)
        issue_wr |=> sda_oe_q && req_wr_q && req_dat_q == $past(rx_sh_q) && $changed(req_tgl_q);
    endproperty
    a_data_wr: assert property (p_data_wr) else $error("data byte lost");

    property p_idx_step;
        @(posedge link_clk) disable iff (!lrst_q)
        issue_wr || issue_dat |=> idx_q == $past(idx_q) + 8'h01;
    endproperty
    a_idx_step: assert property (p_idx_step) else $error("index did not step");

    property p_rd_addr;
        @(posedge link_clk) disable iff (!lrst_q)
        issue_cnt |=> sda_oe_q && !req_wr_q && req_idx_q == IDX_COUNT ##1 busy [*2];
    endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("read address handling wrong");

    property p_count_first;
        @(posedge link_clk) disable iff (!lrst_q)
        state_q == ST_LOAD && !busy && first_q |=> tx_sh_q == left_q && state_q == ST_TX;
    endproperty
    a_count_first: assert property (p_count_first) else $error("count not sent first");

    property p_exhausted;
        @(posedge link_clk) disable iff (!lrst_q)
        host_ack && left_q == 8'h00 ##[1:1000] state_q == ST_LOAD && !busy |=> tx_sh_q == TX_IDLE_BYTE;
    endproperty
    a_exhausted: assert property (p_exhausted) else $error("extra byte beyond count");

    property p_mask;
        @(posedge sys_clk) disable iff (!rst_n)
        push |-> (wr_val & ~sib_wmask(req_idx_q)) == 8'h00 ##1 ack_tgl_q != $past(ack_tgl_q);
    endproperty
    a_mask: assert property (p_mask) else $error("protected bit written");

    c_write: cover property (@(posedge link_clk) disable iff (!lrst_q) issue_wr);
    c_read:  cover property (@(posedge link_clk) disable iff (!lrst_q) issue_dat);
    c_hold:  cover property (@(posedge link_clk) disable iff (!lrst_q) scl_oe_q);
    c_full:  cover property (@(posedge sys_clk) disable iff (!rst_n) v1_q && !cfg_ready);

endmodule : sib_smbus_slave

// ---- test/sib_host_model.sv ----
// host side of the two-wire link; lines are open drain with pull-ups
module sib_host_model (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low,
    output logic      tmo
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int QTR = 1250;
    event       obs_ev;
    logic [7:0] obs_val;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        tmo     = 1'b0;
    end

    // release clock, tolerate stretching, but never wait forever
    task automatic scl_up;
        int n;
        scl_low = 1'b0;
        n = 0;
        while (scl !== 1'b1 && n < 4000) begin
            #20;
            n++;
        end
        if (n >= 4000) tmo = 1'b1;
        #QTR;
    endtask : scl_up

    // start and repeated start alike
    task automatic start;
        sda_low = 1'b0;
        #QTR;
        scl_up();
        sda_low = 1'b1;
        #QTR;
        scl_low = 1'b1;
        #QTR;
    endtask : start

    task automatic stop;
        sda_low = 1'b1;
        #QTR;
        scl_up();
        sda_low = 1'b0;
        #(2 * QTR);
    endtask : stop

    task automatic bit_out(input logic b);
        sda_low = !b;
        #QTR;
        scl_up();
        scl_low = 1'b1;
        #QTR;
    endtask : bit_out

    task automatic bit_in(output logic b);
        sda_low = 1'b0;
        #QTR;
        scl_up();
        b = sda;
        scl_low = 1'b1;
        #QTR;
    endtask : bit_in

    // msb first, then report the acknowledge seen
    task automatic send(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(a);
        obs_val = {7'h00, ~a};
        ->obs_ev;
    endtask : send

    // acknowledge all but the last byte
    task automatic recv(input logic last);
        for (int i = 7; i >= 0; i--) bit_in(obs_val[i]);
        ->obs_ev;
        bit_out(last);
    endtask : recv
endmodule : sib_host_model

// ---- test/tb_smbus_index_block_slave.sv ----
module tb_smbus_index_block_slave;
    import sib_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // -----------------------------------------------------------
    // signals and clocks
    // -----------------------------------------------------------
    localparam logic [7:0] VREV = 8'h3C; // value arbitrary
    localparam logic [7:0] DEVI = 8'hC3; // value arbitrary
    logic        sys_clk, link_clk, rst_n, freq_strap, cfg_ready, stall;
    logic        scl_out, scl_oe, sda_out, sda_oe, cfg_valid, h_scl_low, h_sda_low, tmo;
    logic  [7:0] cfg_index, cfg_data, wv;
    logic  [7:0] regv[10];
    logic  [7:0] mask[10];
    logic  [7:0] exp_q[$];
    logic [15:0] cfg_q[$];
    int          n_errors, samples_checked;
    wire logic   scl_w = !(scl_oe | h_scl_low);
    wire logic   sda_w = !(sda_oe | h_sda_low);

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #17;
        forever #40 link_clk = ~link_clk;
    end

    sib_smbus_slave #(.VEND_REV_ID(VREV), .DEVICE_ID(DEVI)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl_w), .sda_in(sda_w),
        .freq_strap(freq_strap), .cfg_ready(cfg_ready), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_out(sda_out), .sda_oe(sda_oe), .cfg_valid(cfg_valid), .cfg_index(cfg_index),
        .cfg_data(cfg_data));
    sib_host_model u_host (.scl(scl_w), .sda(sda_w), .scl_low(h_scl_low), .sda_low(h_sda_low), .tmo(tmo));

    // -----------------------------------------------------------
    // checking
    // -----------------------------------------------------------
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, e, s);
        end
    endtask : check

    task automatic tally_and_finish;
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // oldest note against each byte or ack the host sees
    always @(u_host.obs_ev) begin
        if (exp_q.size() == 0) check("bus extra", 16'hFFFF, {8'h00, u_host.obs_val});
        else check("bus byte", {8'h00, exp_q.pop_front()}, {8'h00, u_host.obs_val});
    end
    always @(posedge sys_clk) begin
        if (rst_n && cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
            if (cfg_q.size() == 0) check("cfg extra", 16'hFFFF, {cfg_index, cfg_data});
            else check("cfg write", cfg_q.pop_front(), {cfg_index, cfg_data});
        end
    end
    // consumer stalls on demand, else random readiness
    always @(posedge sys_clk) begin
        #5;
        cfg_ready = stall ? 1'b0 : 1'($urandom % 2);
    end
    always @(posedge tmo) begin
        n_errors++;
        tally_and_finish();
    end

    // -----------------------------------------------------------
    // transfers
    // -----------------------------------------------------------
    task automatic wr_byte(input logic [7:0] b, input logic ack);
        exp_q.push_back({7'h00, ack});
        u_host.send(b);
    endtask : wr_byte

    // count byte first, then bytes from idx; past the count reads FF
    task automatic blk_read(input logic [7:0] idx, input int n);
        u_host.start();
        wr_byte(ADDR_WR, 1'b1);
        wr_byte(idx, 1'b1);
        u_host.start();
        wr_byte(ADDR_RD, 1'b1);
        for (int i = 0; i < n; i++) begin
            if (i == 0) exp_q.push_back(regv[8]);
            else if (i > regv[8]) exp_q.push_back(8'hFF);
            else exp_q.push_back(idx + i - 1 < 10 ? regv[idx + i - 1] : 8'h00);
            u_host.recv(i == n - 1);
        end
        u_host.stop();
    endtask : blk_read

    initial begin
        rst_n = 1'b0;
        freq_strap = 1'b1;
        stall = 1'b0;
        cfg_ready = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        void'($urandom(32'h756574c5));
        regv = '{RST_B0, RST_B1, RST_B2, 8'h00, 8'h00, RST_B5, RST_B6 | 8'h10, VREV, RST_B8, DEVI};
        mask = '{MSK_B0, MSK_B1, MSK_B2, 8'h00, 8'h00, MSK_B5, MSK_B6, 8'h00, MSK_B8, 8'h00};
        repeat (10) @(posedge sys_clk);
        #5 rst_n = 1'b1;
        #2000;
        blk_read(8'h00, 11);
        // foreign addresses stay unanswered
        foreach (regv[k]) if (k < 2) begin
            u_host.start();
            wr_byte(k == 0 ? 8'hA4 : 8'hD0, 1'b0);
            u_host.stop();
        end
        // write while the consumer stalls; buffer must hold the bus
        stall = 1'b1;
        // released well inside the host's 80 us stretch limit
        fork #240000 stall = 1'b0; join_none
        u_host.start();
        wr_byte(ADDR_WR, 1'b1);
        wr_byte(8'h00, 1'b1);
        wr_byte(8'h06, 1'b1);
        for (int i = 0; i < 6; i++) begin
            wv = 8'($urandom);
            regv[i] = (wv & mask[i]) | (regv[i] & ~mask[i]);
            cfg_q.push_back({8'(i), regv[i]});
            wr_byte(wv, 1'b1);
        end
        u_host.stop();
        // new count then a read that runs past it
        u_host.start();
        wr_byte(ADDR_WR, 1'b1);
        wr_byte(IDX_COUNT, 1'b1);
        wr_byte(8'h01, 1'b1);
        regv[8] = 8'h03;
        cfg_q.push_back({IDX_COUNT, 8'h03});
        wr_byte(8'h03, 1'b1);
        u_host.stop();
        blk_read(8'h05, 5);
        #20000;
        check("notes left", 16'h0000, 16'(exp_q.size() + cfg_q.size()));
        check("pin drive level", 16'h0000, {14'h0000, scl_out, sda_out});
        tally_and_finish();
    end
endmodule : tb_smbus_index_block_slave
